//--- pmr_pkg.sv
`default_nettype none
package pmr_pkg;

   // ==========================================================
   // Register map, byte addresses on the APB bus
   localparam int            ADDR_W        = 8;
   localparam logic [7:0]    CTRL_STAT_OFF = 8'h74;
   localparam logic [7:0]    TIMERS_OFF    = 8'h78;
   localparam logic [7:0]    IRQ_STAT_OFF  = 8'h90;
   localparam logic [7:0]    IRQ_MASK_OFF  = 8'h94;

   // ==========================================================
   // Field layout
   localparam int            PME_EN_BIT    = 8;
   localparam int            PME_ST_BIT    = 15;
   localparam int            L1_LSB        = 0;
   localparam int            L1_W          = 16;
   localparam int            L0S_LSB       = 16;
   localparam int            L0S_W         = 12;
   localparam int            LAYOUT_BIT    = 31;
   localparam int            STATE_W       = 6;

   // ==========================================================
   // Values after reset
   localparam logic [15:0]   L1_RST        = 16'h03E8;
   localparam logic [11:0]   L0S_RST       = 12'h6D6;

   // ==========================================================
   // Timing: L1 counts 1 us ticks, L0s counts 4 ns ticks
   localparam int            CLK_PERIOD_NS = 40;
   localparam int            L1_TICK_NS    = 1000;
   localparam int            L0S_TICK_NS   = 4;
   localparam int            L1_PRESCALE   = L1_TICK_NS / CLK_PERIOD_NS;
   localparam int            L0S_STEP      = CLK_PERIOD_NS / L0S_TICK_NS;

   // ==========================================================
   // Interrupt status bits
   localparam int            IRQ_N         = 3;
   localparam int            IRQ_PME       = 0;
   localparam int            IRQ_L1        = 1;
   localparam int            IRQ_L0S       = 2;

   typedef enum logic [2:0] {
      APB_IDLE   = 3'b001,
      APB_ACCESS = 3'b010,
      APB_RESP   = 3'b100
   } pmr_apb_st_t;

endpackage
`default_nettype wire

//--- pmr_entry_timer.sv
`default_nettype none
module pmr_entry_timer #(
   parameter int LIMIT_W  = 16,
   parameter int PRESCALE = 1,
   parameter int STEP     = 1
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               cond,
   input  wire logic [LIMIT_W-1:0] limit,
   output logic                    enter_q
);
   import pmr_pkg::*;

   localparam int ACC_W = LIMIT_W + 1;
   localparam int PS_W  = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [ACC_W-1:0] CAP   = ACC_W'(1) << LIMIT_W;
   localparam logic [ACC_W-1:0] STEPV = ACC_W'(STEP);
   localparam logic [PS_W-1:0]  PSMAX = PS_W'(PRESCALE - 1);

   generate
      if (PRESCALE < 1 || STEP < 1 || LIMIT_W < 1 || STEP >= (1 << LIMIT_W)) begin : g_bad
         $error("pmr_entry_timer: unusable parameters");
      end
   endgenerate

   logic [PS_W-1:0]  presc_q;
   logic [PS_W-1:0]  presc_d;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [ACC_W:0]   acc_sum;
   logic             tick;
   logic             enter_d;

   // Elapsed time saturates so a held condition never wraps back below the limit
   assign tick    = (presc_q == PSMAX);
   assign acc_sum = {1'b0, acc_q} + {1'b0, STEPV};
   assign presc_d = (!cond || tick) ? '0 : presc_q + PS_W'(1);
   assign acc_d   = !cond ? '0 :
                    !tick ? acc_q :
                    (acc_sum >= {1'b0, CAP}) ? CAP : acc_sum[ACC_W-1:0];
   assign enter_d = cond && (acc_q >= {1'b0, limit});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= '0;
         acc_q   <= '0;
         enter_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         acc_q   <= acc_d;
         enter_q <= enter_d;
      end
   end
endmodule
`default_nettype wire

//--- pmr_irq_bank.sv
`default_nettype none
module pmr_irq_bank #(
   parameter int N = 3
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] event_in,
   input  wire logic         clr_we,
   input  wire logic         mask_we,
   input  wire logic [N-1:0] wdata,
   output logic [N-1:0]      status_q,
   output logic [N-1:0]      mask_q,
   output logic              irq_q
);
   import pmr_pkg::*;

   generate
      if (N < 1 || N > 32) begin : g_bad
         $error("pmr_irq_bank: N out of range");
      end
   endgenerate

   logic [N-1:0] status_d;
   logic [N-1:0] mask_d;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // An event in the clearing cycle survives the clear
         assign status_d[i] = event_in[i] | (status_q[i] & ~(clr_we & wdata[i]));
      end
   endgenerate

   assign mask_d = mask_we ? wdata : mask_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
         mask_q   <= '0;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_d;
         irq_q    <= |(status_d & mask_d);
      end
   end
endmodule
`default_nettype wire

//--- pmr_port_pm_regs.sv
// Behaviour
// - PME messages are sent only while the port's PME enable bit 8 is set.
// - Upstream port never sends PME; its enable bit reads zero, ignores writes.
// - PME enable survives hot reset; on downstream ports it is sticky.
// - PME status bit 15 sets when port originates PME; writing one clears it.
// - Forwarding another agent's PME leaves PME status untouched.
// - Data select, data scale and data byte fields always read zero.
// - Bits 22 and 23 (bus low power, bus power/clock control) read zero.
// - L1 entry after conditions hold for 16-bit timer, 1 us units, reset 0x3E8.
// - L1 timer applies on upstream port only; downstream ignores its value.
// - L0s entry after conditions hold for 12-bit timer, 4 ns units, reset 0x6D6.
// - Bit 31 zero shows the timer layout; one shows the state layout.
// - State layout shows the 6-bit power-management state code in low bits.
`default_nettype none
module pmr_port_pm_regs #(
   parameter bit UPSTREAM_PORT = 1'b0
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pmr_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        hot_reset,
   input  wire logic                        pme_request,
   input  wire logic                        pme_forward_in,
   output logic                             pme_msg_send,
   output logic                             pme_msg_forward,
   input  wire logic                        l1_conditions_met,
   input  wire logic                        l0s_conditions_met,
   input  wire logic [pmr_pkg::STATE_W-1:0] pm_state_code,
   output logic                             tx_enter_l1,
   output logic                             tx_enter_l0s,
   output logic                             irq
);
   import pmr_pkg::*;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]) && (a[1:0] == 2'b00);
   endfunction

   generate
      if ((L1_TICK_NS % CLK_PERIOD_NS) != 0 || (CLK_PERIOD_NS % L0S_TICK_NS) != 0) begin : g_bad
         $error("pmr_port_pm_regs: clock period does not divide the timer ticks");
      end
   endgenerate

   // ==========================================================
   // APB slave: one wait state, read data and error from flops
   pmr_apb_st_t       st_q;
   pmr_apb_st_t       st_d;
   logic [31:0]       rd_mux;
   logic              hit_ctrl;
   logic              hit_timers;
   logic              hit_stat;
   logic              hit_mask;
   logic              hit_any;
   logic              commit;
   logic              wr_ctrl;
   logic              wr_timers;
   logic              wr_stat;
   logic              wr_mask;

   assign hit_ctrl   = addr_is(paddr, CTRL_STAT_OFF);
   assign hit_timers = addr_is(paddr, TIMERS_OFF);
   assign hit_stat   = addr_is(paddr, IRQ_STAT_OFF);
   assign hit_mask   = addr_is(paddr, IRQ_MASK_OFF);
   assign hit_any    = hit_ctrl | hit_timers | hit_stat | hit_mask;
   // Writes land only on the edge where pready is sampled high
   assign commit     = (st_q == APB_RESP) && psel && penable && pwrite;
   assign wr_ctrl    = commit && hit_ctrl;
   assign wr_timers  = commit && hit_timers;
   assign wr_stat    = commit && hit_stat;
   assign wr_mask    = commit && hit_mask;

   always_comb begin
      case (st_q)
         APB_IDLE:   st_d = (psel && !penable) ? APB_ACCESS : APB_IDLE;
         APB_ACCESS: st_d = (psel && penable) ? APB_RESP : APB_ACCESS;
         APB_RESP:   st_d = APB_IDLE;
         default:    st_d = APB_IDLE;
      endcase
   end

   // ==========================================================
   // PME control and status
   logic pme_enable_q;
   logic pme_enable_d;
   logic pme_status_q;
   logic pme_status_d;

   // Upstream port holds both bits at zero; hot reset is not a term here, so both survive it
   assign pme_enable_d = !UPSTREAM_PORT && (wr_ctrl ? pwdata[PME_EN_BIT] : pme_enable_q);
   assign pme_status_d = !UPSTREAM_PORT &&
                         (pme_request || (pme_status_q && !(wr_ctrl && pwdata[PME_ST_BIT])));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pme_enable_q    <= 1'b0;
         pme_status_q    <= 1'b0;
         pme_msg_send    <= 1'b0;
         pme_msg_forward <= 1'b0;
      end else begin
         pme_enable_q    <= pme_enable_d;
         pme_status_q    <= pme_status_d;
         pme_msg_send    <= pme_request && pme_enable_q && !UPSTREAM_PORT;
         pme_msg_forward <= pme_forward_in;
      end
   end

   // ==========================================================
   // Link entry timers and layout select
   logic [L1_W-1:0]  l1_timer_q;
   logic [L1_W-1:0]  l1_timer_d;
   logic [L0S_W-1:0] l0s_timer_q;
   logic [L0S_W-1:0] l0s_timer_d;
   logic             layout_q;
   logic             layout_d;
   logic [L1_W-1:0]  l1_limit;

   // Timer fields are read-only while the state layout is shown
   assign l1_timer_d  = hot_reset ? L1_RST :
                        (wr_timers && !layout_q) ? pwdata[L1_LSB +: L1_W] : l1_timer_q;
   assign l0s_timer_d = hot_reset ? L0S_RST :
                        (wr_timers && !layout_q) ? pwdata[L0S_LSB +: L0S_W] : l0s_timer_q;
   assign layout_d    = hot_reset ? 1'b0 : wr_timers ? pwdata[LAYOUT_BIT] : layout_q;
   // Downstream entry follows the conditions alone
   assign l1_limit    = UPSTREAM_PORT ? l1_timer_q : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l1_timer_q  <= L1_RST;
         l0s_timer_q <= L0S_RST;
         layout_q    <= 1'b0;
      end else begin
         l1_timer_q  <= l1_timer_d;
         l0s_timer_q <= l0s_timer_d;
         layout_q    <= layout_d;
      end
   end

   pmr_entry_timer #(
      .LIMIT_W  (L1_W),
      .PRESCALE (L1_PRESCALE),
      .STEP     (1)
   ) u_l1_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .cond     (l1_conditions_met),
      .limit    (l1_limit),
      .enter_q  (tx_enter_l1)
   );

   // The clock is slower than a 4 ns tick, so each cycle adds several ticks
   pmr_entry_timer #(
      .LIMIT_W  (L0S_W),
      .PRESCALE (1),
      .STEP     (L0S_STEP)
   ) u_l0s_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .cond     (l0s_conditions_met),
      .limit    (l0s_timer_q),
      .enter_q  (tx_enter_l0s)
   );

   // ==========================================================
   // Interrupts
   logic             l1_prev_q;
   logic             l0s_prev_q;
   logic [IRQ_N-1:0] irq_event;
   logic [IRQ_N-1:0] irq_status;
   logic [IRQ_N-1:0] irq_mask;

   assign irq_event[IRQ_PME] = pme_request && !UPSTREAM_PORT;
   assign irq_event[IRQ_L1]  = tx_enter_l1 && !l1_prev_q;
   assign irq_event[IRQ_L0S] = tx_enter_l0s && !l0s_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l1_prev_q  <= 1'b0;
         l0s_prev_q <= 1'b0;
      end else begin
         l1_prev_q  <= tx_enter_l1;
         l0s_prev_q <= tx_enter_l0s;
      end
   end

   pmr_irq_bank #(
      .N        (IRQ_N)
   ) u_irq (
      .pclk     (pclk),
      .presetn  (presetn),
      .event_in (irq_event),
      .clr_we   (wr_stat),
      .mask_we  (wr_mask),
      .wdata    (pwdata[IRQ_N-1:0]),
      .status_q (irq_status),
      .mask_q   (irq_mask),
      .irq_q    (irq)
   );

   // ==========================================================
   // Read data: all unlisted bits, data fields and reserved fields are zero
   logic [31:0] ctrl_rd;
   logic [31:0] timers_rd;

   assign ctrl_rd   = {16'h0000, pme_status_q, 6'h00, pme_enable_q, 8'h00};
   assign timers_rd = layout_q ? {layout_q, 25'h0000000, pm_state_code} :
                                 {layout_q, 3'h0, l0s_timer_q, l1_timer_q};
   assign rd_mux    = hit_ctrl   ? ctrl_rd :
                      hit_timers ? timers_rd :
                      hit_stat   ? {29'h00000000, irq_status} :
                      hit_mask   ? {29'h00000000, irq_mask} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= APB_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         st_q    <= st_d;
         pready  <= (st_d == APB_RESP);
         pslverr <= (st_d == APB_RESP) && !hit_any;
         if (st_d == APB_RESP && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Checks
   logic [23:0] l1_hold_q;
   logic [23:0] l0s_hold_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l1_hold_q  <= '0;
         l0s_hold_q <= '0;
      end else begin
         l1_hold_q  <= !l1_conditions_met ? '0 : (&l1_hold_q) ? l1_hold_q : l1_hold_q + 24'h000001;
         l0s_hold_q <= !l0s_conditions_met ? '0 : (&l0s_hold_q) ? l0s_hold_q : l0s_hold_q + 24'h000001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ctrl_read;
      pready && psel && penable && !pwrite && hit_ctrl;
   endsequence

   sequence s_timers_read;
      pready && psel && penable && !pwrite && hit_timers;
   endsequence

   property p_send_needs_enable;
      pme_msg_send |-> $past(pme_request) && $past(pme_enable_q);
   endproperty
   a_send_needs_enable: assert property (p_send_needs_enable) else $error("PME sent while disabled");

   property p_upstream_silent;
      UPSTREAM_PORT |-> !pme_msg_send && !pme_enable_q && !pme_status_q;
   endproperty
   a_upstream_silent: assert property (p_upstream_silent) else $error("upstream port PME bits active");

   property p_enable_survives_hot_reset;
      hot_reset && !wr_ctrl |=> pme_enable_q == $past(pme_enable_q);
   endproperty
   a_enable_survives_hot_reset: assert property (p_enable_survives_hot_reset)
      else $error("PME enable lost on hot reset");

   property p_enable_write;
      wr_ctrl && !UPSTREAM_PORT && pwdata[PME_EN_BIT] |=> pme_enable_q;
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("PME enable write not taken");

   property p_status_sets;
      pme_request && !UPSTREAM_PORT |=> pme_status_q;
   endproperty
   a_status_sets: assert property (p_status_sets) else $error("PME status not set");

   property p_status_clears;
      wr_ctrl && pwdata[PME_ST_BIT] && !pme_request |=> !pme_status_q;
   endproperty
   a_status_clears: assert property (p_status_clears) else $error("PME status not cleared");

   property p_forward_keeps_status;
      pme_forward_in && !pme_request && !wr_ctrl |=> $stable(pme_status_q);
   endproperty
   a_forward_keeps_status: assert property (p_forward_keeps_status) else $error("forwarding moved PME status");

   property p_ctrl_zero_fields;
      s_ctrl_read |-> prdata[14:9] == 6'h00 && prdata[31:16] == 16'h0000 && prdata[7:0] == 8'h00;
   endproperty
   a_ctrl_zero_fields: assert property (p_ctrl_zero_fields) else $error("control fixed fields nonzero");

   property p_bus_power_bits_zero;
      s_ctrl_read |-> prdata[23:22] == 2'b00;
   endproperty
   a_bus_power_bits_zero: assert property (p_bus_power_bits_zero) else $error("bus power bits nonzero");

   property p_l1_timer_held;
      $rose(tx_enter_l1) |-> 32'(l1_hold_q) >= 32'(l1_limit) * L1_PRESCALE;
   endproperty
   a_l1_timer_held: assert property (p_l1_timer_held) else $error("L1 entered too early");

   property p_downstream_l1_prompt;
      !UPSTREAM_PORT && l1_conditions_met |=> tx_enter_l1;
   endproperty
   a_downstream_l1_prompt: assert property (p_downstream_l1_prompt) else $error("downstream L1 entry late");

   property p_l0s_timer_held;
      $rose(tx_enter_l0s) |-> 32'(l0s_hold_q) * L0S_STEP >= 32'(l0s_timer_q);
   endproperty
   a_l0s_timer_held: assert property (p_l0s_timer_held) else $error("L0s entered too early");

   property p_hot_reset_timers;
      hot_reset |=> l1_timer_q == L1_RST && l0s_timer_q == L0S_RST && !layout_q;
   endproperty
   a_hot_reset_timers: assert property (p_hot_reset_timers)
      else $error("timers not restored by hot reset");

   property p_layout_view;
      s_timers_read |-> prdata[LAYOUT_BIT] == layout_q &&
                        (layout_q ? prdata[30:6] == 25'h0000000 : prdata[30:28] == 3'h0);
   endproperty
   a_layout_view: assert property (p_layout_view) else $error("timer register layout wrong");

   property p_layout_locks_timers;
      wr_timers && layout_q && !hot_reset |=> $stable(l1_timer_q) && $stable(l0s_timer_q);
   endproperty
   a_layout_locks_timers: assert property (p_layout_locks_timers)
      else $error("timer fields moved while locked");

   property p_state_code;
      (s_timers_read and layout_q) |-> prdata[STATE_W-1:0] == $past(pm_state_code);
   endproperty
   a_state_code: assert property (p_state_code) else $error("state code not shown");

endmodule
`default_nettype wire

//--- pmr_link_partner.sv
`default_nettype none
// ==========================================================
// Link side: PME events, hot reset, entry conditions, state
module pmr_link_partner (
   input  wire logic                    pclk,
   output logic                         hot_reset,
   output logic                         pme_request,
   output logic                         pme_forward_in,
   output logic                         l1_cond,
   output logic                         l0s_cond,
   output logic [pmr_pkg::STATE_W-1:0]  state_code
);
   import pmr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      hot_reset      = 1'b0;
      pme_request    = 1'b0;
      pme_forward_in = 1'b0;
      l1_cond        = 1'b0;
      l0s_cond       = 1'b0;
      state_code     = '0;
   end

   // One-cycle pulse: 0 originate PME, 1 forward PME, 2 hot reset
   task pulse(input int kind);
      @(posedge pclk);
      pme_request    <= (kind == 0);
      pme_forward_in <= (kind == 1);
      hot_reset      <= (kind == 2);
      @(posedge pclk);
      pme_request    <= 1'b0;
      pme_forward_in <= 1'b0;
      hot_reset      <= 1'b0;
   endtask

   task set_cond(input logic l1, input logic l0s);
      @(posedge pclk);
      l1_cond  <= l1;
      l0s_cond <= l0s;
   endtask

   task set_state(input logic [STATE_W-1:0] c);
      @(posedge pclk);
      state_code <= c;
   endtask
endmodule
`default_nettype wire

//--- pmr_port_pm_regs_tb.sv
`default_nettype none
module pmr_port_pm_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pmr_pkg::*;

   logic                pclk;
   logic                presetn;
   logic                penable;
   logic                pwrite;
   logic [1:0]          psel_v;
   logic [1:0]          pready_v;
   logic [1:0]          pslverr_v;
   logic [1:0]          send_v;
   logic [1:0]          fwd_v;
   logic [1:0]          el1_v;
   logic [1:0]          el0s_v;
   logic [1:0]          irq_v;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic [31:0]         rd;
   logic [31:0]         rdata_v [2];
   logic                err;
   logic                hot_reset;
   logic                pme_req;
   logic                pme_fwd;
   logic                l1_c;
   logic                l0s_c;
   logic [STATE_W-1:0]  state_code;
   logic [STATE_W-1:0]  codes [3];
   int                  miscompares;
   int                  n_tests;
   int                  cycles;

   // ==========================================================
   // Port 0 downstream, port 1 upstream, sharing the link side
   for (genvar g = 0; g < 2; g++) begin : g_port
      pmr_port_pm_regs #(.UPSTREAM_PORT(g == 1)) dut_u (
         .pclk               (pclk),
         .presetn            (presetn),
         .psel               (psel_v[g]),
         .penable            (penable),
         .pwrite             (pwrite),
         .paddr              (paddr),
         .pwdata             (pwdata),
         .prdata             (rdata_v[g]),
         .pready             (pready_v[g]),
         .pslverr            (pslverr_v[g]),
         .hot_reset          (hot_reset),
         .pme_request        (pme_req),
         .pme_forward_in     (pme_fwd),
         .pme_msg_send       (send_v[g]),
         .pme_msg_forward    (fwd_v[g]),
         .l1_conditions_met  (l1_c),
         .l0s_conditions_met (l0s_c),
         .pm_state_code      (state_code),
         .tx_enter_l1        (el1_v[g]),
         .tx_enter_l0s       (el0s_v[g]),
         .irq                (irq_v[g])
      );
   end

   pmr_link_partner partner_u (
      .pclk           (pclk),
      .hot_reset      (hot_reset),
      .pme_request    (pme_req),
      .pme_forward_in (pme_fwd),
      .l1_cond        (l1_c),
      .l0s_cond       (l0s_c),
      .state_code     (state_code)
   );

   // ==========================================================
   // Clock and hang guard
   always #20 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles++;
      if (cycles >= 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // APB master: holds the request until pready is sampled high
   task apb(input int p, input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel_v  <= 2'b01 << p;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit here: a slave that never answers is caught by the cycle guard
      do begin
         @(posedge pclk);
      end while (pready_v[p] !== 1'b1);
      rd  = rdata_v[p];
      err = pslverr_v[p];
      psel_v  <= 2'b00;
      penable <= 1'b0;
   endtask

   task rdchk(input int p, input logic [7:0] a, input logic [31:0] exp);
      apb(p, 1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      pclk = 0; presetn = 0; penable = 0; pwrite = 0; psel_v = 0;
      paddr = 0; pwdata = 0; miscompares = 0; n_tests = 0; cycles = 0;
      codes = '{6'd0, 6'd35, 6'd63};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         rdchk(p, CTRL_STAT_OFF, 32'h0);
         rdchk(p, TIMERS_OFF, 32'h06D603E8);
         rdchk(p, IRQ_STAT_OFF, 32'h0);
         // Boot-time setting of the enable, as an init image would do it
         apb(p, 1'b1, CTRL_STAT_OFF, 32'hFFFFFFFF);
         rdchk(p, CTRL_STAT_OFF, (p == 0) ? 32'h100 : 32'h0);
         apb(p, 1'b1, IRQ_MASK_OFF, 32'h7);
      end
      apb(0, 1'b0, 8'h80, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      $display("test reset_and_fields done");

      partner_u.pulse(0);
      #1 check({send_v, irq_v}, 4'b0101);
      rdchk(0, CTRL_STAT_OFF, 32'h8100);
      rdchk(1, CTRL_STAT_OFF, 32'h0);
      apb(0, 1'b1, CTRL_STAT_OFF, 32'h0);
      apb(0, 1'b1, IRQ_MASK_OFF, 32'h0);
      partner_u.pulse(0);
      #1 check({send_v, irq_v}, 4'b0000);
      rdchk(0, CTRL_STAT_OFF, 32'h8000);
      apb(0, 1'b1, CTRL_STAT_OFF, 32'h8000);
      rdchk(0, CTRL_STAT_OFF, 32'h0);
      rdchk(0, IRQ_STAT_OFF, 32'h1);
      apb(0, 1'b1, IRQ_STAT_OFF, 32'h7);
      rdchk(0, IRQ_STAT_OFF, 32'h0);
      partner_u.pulse(1);
      #1 check(fwd_v, 2'b11);
      rdchk(0, CTRL_STAT_OFF, 32'h0);
      $display("test pme done");

      apb(0, 1'b1, CTRL_STAT_OFF, 32'h100);
      apb(0, 1'b1, TIMERS_OFF, 32'h80640002);
      partner_u.pulse(0);
      partner_u.pulse(2);
      rdchk(0, CTRL_STAT_OFF, 32'h8100);
      rdchk(0, TIMERS_OFF, 32'h06D603E8);
      $display("test hot_reset done");

      apb(0, 1'b1, TIMERS_OFF, 32'h80000000);
      apb(0, 1'b1, TIMERS_OFF, 32'hFFFFFFFF);
      foreach (codes[i]) begin
         partner_u.set_state(codes[i]);
         rdchk(0, TIMERS_OFF, {1'b1, 25'h0, codes[i]});
      end
      // Timer fields stay locked on the write that leaves the state layout
      apb(0, 1'b1, TIMERS_OFF, 32'h00640002);
      rdchk(0, TIMERS_OFF, 32'h00000000);
      apb(0, 1'b1, TIMERS_OFF, 32'h00640002);
      rdchk(0, TIMERS_OFF, 32'h00640002);
      apb(1, 1'b1, TIMERS_OFF, 32'h00640002);
      apb(0, 1'b1, IRQ_STAT_OFF, 32'h7);
      $display("test layout done");

      partner_u.set_cond(1'b1, 1'b0);
      repeat (3) @(posedge pclk);
      #1 check(el1_v, 2'b01);
      repeat (42) @(posedge pclk);
      #1 check(el1_v, 2'b01);
      repeat (10) @(posedge pclk);
      #1 check(el1_v, 2'b11);
      partner_u.set_cond(1'b0, 1'b1);
      repeat (2) @(posedge pclk);
      #1 check(el1_v, 2'b00);
      repeat (6) @(posedge pclk);
      #1 check(el0s_v, 2'b00);
      repeat (6) @(posedge pclk);
      #1 check(el0s_v, 2'b11);
      partner_u.set_cond(1'b0, 1'b0);
      rdchk(0, IRQ_STAT_OFF, 32'h6);
      $display("test entry_timers done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
